// >>> rtl/sfp_flash_guard.sv
// Contract
// - Top/bottom zero: levels 1-5 protect top 1..16 blocks, 6-15 all, 0 none.
// - Top/bottom one: levels 1-5 protect lowest 1..16 blocks, 6-15 all.
// - Chip erase only runs when all four protect bits are zero.
// - OTP area is two 4096-bit rows, offsets 000-1FF and 200-3FF.
// - Security bit 0 reports the factory lock of the second row.
// - Security write command sets customer lock bit 1.
// - A locked OTP row refuses every later change.
// - Enter/exit commands bracket OTP mode; main array blocked inside it.
// - Array is 32 blocks of 64K, 000000h to 1FFFFFh ascending.
// - Unknown command sends device to standby with output off until chip select rises.
// - Known command holds active mode until chip select rises.
// - Inputs sampled on SCLK rise, outputs shifted on SCLK fall; modes 0 and 3.
// - Read commands may end after any output bit.
// - Write-type commands must end on a byte boundary or are rejected.
// - Array commands are ignored while an internal operation runs.
// - Hold pauses only the serial link, never a running operation.
// - Hold begins on hold falling while SCLK low, else when SCLK falls.
// - Hold ends on hold rising while SCLK low, else when SCLK falls.
// - During hold output is off and serial input ignored.
// - Chip select rising during hold resets the interface logic.
// - Hold is disabled in four-line mode.
// - Write-protect pin low with status lock bit set locks protect bits and status lock bit, not in four-line mode.
// - Data-changing commands need the write-enable latch set first.
`timescale 1ns/1ps
module sfp_flash_guard
	import sfp_pkg::*;
(
	// System clock and reset.
	input wire logic clk_sys_in,
	input wire logic rst_b_in,
	// Serial link pins.
	input wire logic cs_b_in,
	input wire logic sclk_in,
	input wire logic si_in,
	input wire logic hold_b_in,
	input wire logic wp_b_in,
	output logic so_out,
	output logic so_oe_out,
	// Configuration and engine status.
	input wire logic top_bottom_select_in,
	input wire logic quad_mode_in,
	input wire logic factory_lock_in,
	input wire logic busy_in,
	// Operation request and visible state.
	output sfp_op_s op_out,
	output logic [3:0] protect_level_out,
	output logic write_enable_latch_out,
	output logic otp_mode_out,
	output logic [1:0] security_out,
	output logic hold_out
);

	localparam int NPIN = 5;
	localparam int P_CS = 0;
	localparam int P_SCLK = 1;
	localparam int P_SI = 2;
	localparam int P_HOLD = 3;
	localparam int P_WP = 4;

	logic [NPIN-1:0] pin_raw;
	logic [NPIN-1:0] pin_m_q;
	logic [NPIN-1:0] pin_s_q;
	logic cs_p_q;
	logic sclk_p_q;
	logic cs_rise;
	logic sclk_rise;
	logic sclk_fall;
	logic shift_en;
	sfp_link_e state_q;
	logic hold_q;
	logic [2:0] bit_q;
	logic [2:0] byte_q;
	logic [7:0] sr_q;
	logic [7:0] byte_nx;
	logic [7:0] cmd_q;
	logic [23:0] addr_q;
	logic [7:0] wdat_q;
	logic [7:0] out_sr_q;
	logic out_en_q;
	logic so_q;
	logic [3:0] level_q;
	logic status_write_lock_bit_q;
	logic wel_q;
	logic otp_q;
	logic cust_q;
	sfp_op_s op_q;
	sfp_op_s op_d;
	logic exec;
	logic ok_simple;
	logic blk_hit;
	logic row_locked;

	function automatic logic blk_prot(input logic [4:0] blk, input logic [3:0] lvl,
		input logic tb);
		logic [5:0] n;
		n = 6'h01 << (lvl - 4'h1);
		if (lvl == 4'h0)
			blk_prot = 1'b0;
		else if (lvl >= SFP_LVL_ALL)
			blk_prot = 1'b1;
		else if (tb)
			blk_prot = {1'b0, blk} < n;
		else
			blk_prot = {1'b0, blk} >= (SFP_BLK_COUNT - n);
	endfunction : blk_prot

	function automatic logic is_known(input logic [7:0] c);
		case (c)
			SFP_OPC_WRITE_ENABLE_CMD, SFP_OPC_WRDI, SFP_OPC_RDSR, SFP_OPC_WRSR, SFP_OPC_PP,
			SFP_OPC_SE, SFP_OPC_BE32, SFP_OPC_BE64, SFP_OPC_CE_A, SFP_OPC_CE_B,
			SFP_OPC_ENTER, SFP_OPC_EXIT, SFP_OPC_SECWR, SFP_OPC_SECRD:
				is_known = 1'b1;
			default:
				is_known = 1'b0;
		endcase
	endfunction : is_known

	// Every pin crosses two flip-flops before any logic looks at it.
	assign pin_raw = {wp_b_in, hold_b_in, si_in, sclk_in, cs_b_in};

	generate
		for (genvar i = 0; i < NPIN; i++)
		begin : g_sync
			always_ff @(posedge clk_sys_in)
			begin
				if (!rst_b_in)
				begin
					pin_m_q[i] <= 1'b1;
					pin_s_q[i] <= 1'b1;
				end
				else
				begin
					pin_m_q[i] <= pin_raw[i];
					pin_s_q[i] <= pin_m_q[i];
				end
			end
		end
	endgenerate

	always_ff @(posedge clk_sys_in)
	begin
		if (!rst_b_in)
		begin
			cs_p_q <= 1'b1;
			sclk_p_q <= 1'b1;
		end
		else
		begin
			cs_p_q <= pin_s_q[P_CS];
			sclk_p_q <= pin_s_q[P_SCLK];
		end
	end

	// Only edges matter, so the idle level of SCLK is free in either mode.
	assign sclk_rise = pin_s_q[P_SCLK] & ~sclk_p_q;
	assign sclk_fall = ~pin_s_q[P_SCLK] & sclk_p_q;
	assign cs_rise = pin_s_q[P_CS] & ~cs_p_q;
	assign shift_en = sclk_rise && !pin_s_q[P_CS] && !hold_q && (state_q != SFP_LS_STANDBY);
	assign byte_nx = {sr_q[6:0], pin_s_q[P_SI]};

	// Hold only freezes the link; busy_in and the op engine are untouched.
	always_ff @(posedge clk_sys_in)
	begin
		if (!rst_b_in)
			hold_q <= 1'b0;
		else if (pin_s_q[P_CS] || quad_mode_in)
			hold_q <= 1'b0;
		else if (!pin_s_q[P_SCLK])
			hold_q <= !pin_s_q[P_HOLD];
	end

	always_ff @(posedge clk_sys_in)
	begin
		if (!rst_b_in)
			state_q <= SFP_LS_IDLE;
		else if (pin_s_q[P_CS])
			state_q <= SFP_LS_IDLE;
		else
		begin
			case (state_q)
				SFP_LS_IDLE:
					state_q <= SFP_LS_CMD;
				SFP_LS_CMD:
					if (shift_en && bit_q == 3'h7)
						state_q <= is_known(byte_nx) ? SFP_LS_ACTIVE : SFP_LS_STANDBY;
				SFP_LS_ACTIVE:
					state_q <= SFP_LS_ACTIVE;
				SFP_LS_STANDBY:
					state_q <= SFP_LS_STANDBY;
				default:
					state_q <= SFP_LS_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_sys_in)
	begin
		if (!rst_b_in || pin_s_q[P_CS])
		begin
			bit_q <= 3'h0;
			byte_q <= 3'h0;
			sr_q <= 8'h00;
			cmd_q <= 8'h00;
			addr_q <= 24'h000000;
			wdat_q <= 8'h00;
		end
		else if (shift_en)
		begin
			sr_q <= byte_nx;
			bit_q <= bit_q + 3'h1;
			if (bit_q == 3'h7)
			begin
				if (byte_q != SFP_BYTES_MAX)
					byte_q <= byte_q + 3'h1;
				if (byte_q == 3'h0)
					cmd_q <= byte_nx;
				else if (byte_q < SFP_BYTES_ADDR)
					addr_q <= {addr_q[15:0], byte_nx};
				if (byte_q == 3'h1)
					wdat_q <= byte_nx;
			end
		end
	end

	// Read data leaves on SCLK falls and may stop after any bit.
	always_ff @(posedge clk_sys_in)
	begin
		if (!rst_b_in || pin_s_q[P_CS])
		begin
			out_en_q <= 1'b0;
			out_sr_q <= 8'h00;
			so_q <= 1'b0;
		end
		else if (shift_en && bit_q == 3'h7 && byte_q == 3'h0)
		begin
			out_sr_q <= (byte_nx == SFP_OPC_SECRD) ? {6'h00, cust_q, factory_lock_in}
				: {status_write_lock_bit_q, 1'b0, level_q, wel_q, busy_in};
			out_en_q <= (byte_nx == SFP_OPC_RDSR) || (byte_nx == SFP_OPC_SECRD);
		end
		else if (sclk_fall && out_en_q && !hold_q)
		begin
			so_q <= out_sr_q[7];
			out_sr_q <= {out_sr_q[6:0], out_sr_q[7]};
		end
	end

	assign so_out = so_q;
	assign so_oe_out = out_en_q && !hold_q && !pin_s_q[P_CS] && (state_q == SFP_LS_ACTIVE);

	// Write-type commands only count when chip select rises on a byte edge.
	assign exec = cs_rise && (state_q == SFP_LS_ACTIVE) && (bit_q == 3'h0) && !busy_in;
	assign ok_simple = exec && (byte_q == SFP_BYTES_ONE);
	assign blk_hit = blk_prot(addr_q[SFP_ADDR_W-1:SFP_BLK_LSB], level_q, top_bottom_select_in);
	assign row_locked = addr_q[SFP_OTP_ROW_BIT] ? factory_lock_in : cust_q;

	always_comb
	begin
		op_d = '0;
		op_d.addr = addr_q[SFP_ADDR_W-1:0];
		op_d.otp = otp_q;
		case (cmd_q)
			SFP_OPC_PP:
				if (byte_q >= SFP_BYTES_PROG)
					op_d.kind = SFP_OP_PP;
			SFP_OPC_SE:
				if (byte_q == SFP_BYTES_ADDR)
					op_d.kind = SFP_OP_SE;
			SFP_OPC_BE32:
				if (byte_q == SFP_BYTES_ADDR)
					op_d.kind = SFP_OP_BE32;
			SFP_OPC_BE64:
				if (byte_q == SFP_BYTES_ADDR)
					op_d.kind = SFP_OP_BE64;
			SFP_OPC_CE_A, SFP_OPC_CE_B:
				if (byte_q == SFP_BYTES_ONE && level_q == 4'h0)
					op_d.kind = SFP_OP_CE;
			SFP_OPC_WRSR:
				if (byte_q == SFP_BYTES_WRSR && !(status_write_lock_bit_q && !pin_s_q[P_WP] && !quad_mode_in))
					op_d.kind = SFP_OP_WRSR;
			default:
				op_d.kind = SFP_OP_NONE;
		endcase
		if (otp_q)
		begin
			if (op_d.kind == SFP_OP_PP && !row_locked)
				op_d.addr = {{(SFP_ADDR_W-SFP_OTP_W){1'b0}}, addr_q[SFP_OTP_W-1:0]};
			else if (op_d.kind != SFP_OP_WRSR)
				op_d.kind = SFP_OP_NONE;
		end
		else if (op_d.kind != SFP_OP_CE && op_d.kind != SFP_OP_WRSR && blk_hit)
			op_d.kind = SFP_OP_NONE;
		op_d.valid = exec && wel_q && (op_d.kind != SFP_OP_NONE);
	end

	always_ff @(posedge clk_sys_in)
	begin
		if (!rst_b_in)
			op_q <= '0;
		else
			op_q <= op_d;
	end

	assign op_out = op_q;

	always_ff @(posedge clk_sys_in)
	begin
		if (!rst_b_in)
			wel_q <= 1'b0;
		else if (ok_simple && cmd_q == SFP_OPC_WRITE_ENABLE_CMD)
			wel_q <= 1'b1;
		else if (op_d.valid || (ok_simple && (cmd_q == SFP_OPC_WRDI || cmd_q == SFP_OPC_SECWR)))
			wel_q <= 1'b0;
	end

	always_ff @(posedge clk_sys_in)
	begin
		if (!rst_b_in)
		begin
			level_q <= SFP_LVL_RST;
			status_write_lock_bit_q <= SFP_STATUS_WRITE_LOCK_BIT_RST;
		end
		else if (op_d.valid && op_d.kind == SFP_OP_WRSR)
		begin
			level_q <= wdat_q[SFP_ST_LVL_LSB+3:SFP_ST_LVL_LSB];
			status_write_lock_bit_q <= wdat_q[SFP_ST_STATUS_WRITE_LOCK_BIT];
		end
	end

	always_ff @(posedge clk_sys_in)
	begin
		if (!rst_b_in)
			otp_q <= 1'b0;
		else if (ok_simple && cmd_q == SFP_OPC_ENTER)
			otp_q <= 1'b1;
		else if (ok_simple && cmd_q == SFP_OPC_EXIT)
			otp_q <= 1'b0;
	end

	// The customer lock never clears short of a reset of the whole part.
	always_ff @(posedge clk_sys_in)
	begin
		if (!rst_b_in)
			cust_q <= SFP_CUST_LOCK_RST;
		else if (ok_simple && cmd_q == SFP_OPC_SECWR && wel_q)
			cust_q <= 1'b1;
	end

	assign protect_level_out = level_q;
	assign write_enable_latch_out = wel_q;
	assign otp_mode_out = otp_q;
	assign security_out = {cust_q, factory_lock_in};
	assign hold_out = hold_q;

	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (!rst_b_in);

	property p_ce_gate;
		op_out.valid && op_out.kind == SFP_OP_CE |-> $past(level_q) == 4'h0;
	endproperty
	a_ce_gate: assert property (p_ce_gate) else $error("chip erase with protect bits set");

	property p_prot;
		op_out.valid && !op_out.otp && op_out.kind inside {SFP_OP_PP, SFP_OP_SE, SFP_OP_BE32,
			SFP_OP_BE64} |-> !blk_prot(op_out.addr[SFP_ADDR_W-1:SFP_BLK_LSB], $past(level_q),
			$past(top_bottom_select_in));
	endproperty
	a_prot: assert property (p_prot) else $error("write into protected block");

	property p_otp_lock;
		op_out.valid && op_out.otp && op_out.kind == SFP_OP_PP |->
			!(op_out.addr[SFP_OTP_ROW_BIT] ? $past(factory_lock_in) : $past(cust_q));
	endproperty
	a_otp_lock: assert property (p_otp_lock) else $error("locked row changed");

	property p_otp_block;
		op_out.valid && op_out.otp |-> op_out.kind inside {SFP_OP_PP, SFP_OP_WRSR};
	endproperty
	a_otp_block: assert property (p_otp_block) else $error("array access in otp mode");

	property p_busy;
		op_out.valid |-> $past(!busy_in) && $past(wel_q) && $past(cs_rise);
	endproperty
	a_busy: assert property (p_busy) else $error("op started while busy or unlatched");

	property p_hold_so;
		hold_q |-> !so_oe_out;
	endproperty
	a_hold_so: assert property (p_hold_so) else $error("output driven in hold");

	property p_standby;
		state_q == SFP_LS_STANDBY |-> !so_oe_out && !op_d.valid;
	endproperty
	a_standby: assert property (p_standby) else $error("standby not quiet");

	property p_quad;
		quad_mode_in |=> !hold_q;
	endproperty
	a_quad: assert property (p_quad) else $error("hold active in quad mode");

	property p_cs_reset;
		$rose(pin_s_q[P_CS]) |=> !hold_q && state_q == SFP_LS_IDLE;
	endproperty
	a_cs_reset: assert property (p_cs_reset) else $error("interface not reset on deselect");

	property p_cust;
		cust_q |=> cust_q;
	endproperty
	a_cust: assert property (p_cust) else $error("customer lock cleared");

	property p_wel_clear;
		op_out.valid |-> !wel_q;
	endproperty
	a_wel_clear: assert property (p_wel_clear) else $error("latch kept after op");

endmodule : sfp_flash_guard

// >>> shared/sfp_pkg.sv
package sfp_pkg;

	// Array geometry: 21 address bits, 64K-byte blocks selected by the top five.
	localparam int SFP_ADDR_W = 21;
	localparam int SFP_BLK_LSB = 16;
	localparam logic [5:0] SFP_BLK_COUNT = 6'h20;
	localparam logic [3:0] SFP_LVL_ALL = 4'h6;

	// One-time-programmable area: row select is offset bit 9.
	localparam int SFP_OTP_W = 10;
	localparam int SFP_OTP_ROW_BIT = 9;

	// Status byte field positions.
	localparam int SFP_ST_BUSY = 0;
	localparam int SFP_ST_WEL = 1;
	localparam int SFP_ST_LVL_LSB = 2;
	localparam int SFP_ST_STATUS_WRITE_LOCK_BIT = 7;

	// Reset values.
	localparam logic [3:0] SFP_LVL_RST = 4'h0;
	localparam logic SFP_STATUS_WRITE_LOCK_BIT_RST = 1'b0;
	localparam logic SFP_CUST_LOCK_RST = 1'b0;

	// Byte counts a command must end on; program needs at least PROG, and the count stops at MAX.
	localparam logic [2:0] SFP_BYTES_ONE = 3'h1;
	localparam logic [2:0] SFP_BYTES_WRSR = 3'h2;
	localparam logic [2:0] SFP_BYTES_ADDR = 3'h4;
	localparam logic [2:0] SFP_BYTES_PROG = 3'h5;
	localparam logic [2:0] SFP_BYTES_MAX = 3'h7;

	// Command opcodes.
	localparam logic [7:0] SFP_OPC_WRITE_ENABLE_CMD = 8'h06;
	localparam logic [7:0] SFP_OPC_WRDI = 8'h04;
	localparam logic [7:0] SFP_OPC_RDSR = 8'h05;
	localparam logic [7:0] SFP_OPC_WRSR = 8'h01;
	localparam logic [7:0] SFP_OPC_PP = 8'h02;
	localparam logic [7:0] SFP_OPC_SE = 8'h20;
	localparam logic [7:0] SFP_OPC_BE32 = 8'h52;
	localparam logic [7:0] SFP_OPC_BE64 = 8'hD8;
	localparam logic [7:0] SFP_OPC_CE_A = 8'h60;
	localparam logic [7:0] SFP_OPC_CE_B = 8'hC7;
	localparam logic [7:0] SFP_OPC_ENTER = 8'hA1;
	localparam logic [7:0] SFP_OPC_EXIT = 8'hA2;
	localparam logic [7:0] SFP_OPC_SECWR = 8'hA3;
	localparam logic [7:0] SFP_OPC_SECRD = 8'hA4;

	typedef enum logic [1:0] {
		SFP_LS_IDLE = 2'b00,
		SFP_LS_CMD = 2'b01,
		SFP_LS_ACTIVE = 2'b10,
		SFP_LS_STANDBY = 2'b11
	} sfp_link_e;

	typedef enum logic [2:0] {
		SFP_OP_NONE = 3'b000,
		SFP_OP_PP = 3'b001,
		SFP_OP_SE = 3'b010,
		SFP_OP_BE32 = 3'b011,
		SFP_OP_BE64 = 3'b100,
		SFP_OP_CE = 3'b101,
		SFP_OP_WRSR = 3'b110
	} sfp_op_e;

	typedef struct packed {
		logic valid;
		sfp_op_e kind;
		logic otp;
		logic [SFP_ADDR_W-1:0] addr;
	} sfp_op_s;

endpackage : sfp_pkg

// >>> tb/sfp_host_model.sv
`timescale 1ns/1ps
module sfp_host_model (
	// Clock and returned data.
	input wire logic clk_in,
	input wire logic so_in,
	// Link pins toward the device.
	output logic cs_b_out,
	output logic sclk_out,
	output logic si_out,
	output logic hold_b_out
);
	logic sclk_idle;

	// Serial clock idles at sclk_idle between frames: low is mode 0, high is mode 3.
	initial
	begin
		sclk_idle = 1'b0;
		cs_b_out = 1'b1;
		sclk_out = 1'b0;
		si_out = 1'b1;
		hold_b_out = 1'b1;
	end

	task automatic wait_clk(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask : wait_clk

	task automatic begin_frame();
		cs_b_out = 1'b0;
		wait_clk(4);
	endtask : begin_frame

	// Each bit is set up after a falling edge and read back just before the rise.
	task automatic shift(input logic [7:0] d, input int n, output logic [7:0] rx);
		rx = 8'h00;
		for (int i = 7; i > 7 - n; i--)
		begin
			if (sclk_idle)
				sclk_out = 1'b0;
			si_out = d[i];
			wait_clk(4);
			rx = {rx[6:0], so_in};
			sclk_out = 1'b1;
			wait_clk(4);
			if (!sclk_idle)
				sclk_out = 1'b0;
		end
	endtask : shift

	// The idle level may only move while chip select is high, or it would clock a bit.
	task automatic set_mode3(input logic v);
		sclk_idle = v;
		sclk_out = v;
		wait_clk(4);
	endtask : set_mode3

	// The data line is turned over on release so a stale level is never mistaken for data.
	task automatic end_frame();
		wait_clk(4);
		cs_b_out = 1'b1;
		si_out = ~si_out;
		wait_clk(6);
	endtask : end_frame

	task automatic set_hold(input logic v);
		hold_b_out = v;
		wait_clk(6);
	endtask : set_hold
endmodule : sfp_host_model

// >>> tb/serial_flash_protect_otp_hold_tb.sv
`timescale 1ns/1ps
module serial_flash_protect_otp_hold_tb
	import sfp_pkg::*;
;
	logic clk_sys_in, rst_b_in, cs_b, sclk, si, hold_b, so, so_oe, op_seen, lk, write_enable_latch, so_line;
	logic wp_b_in, top_bottom_select_in, quad_mode_in, factory_lock_in, busy_in;
	logic write_enable_latch_out, otp_mode_out, hold_out;
	logic [1:0] security_out;
	logic [3:0] protect_level_out, lvl;
	logic [7:0] rx, rnd;
	logic [20:0] adr;
	sfp_op_s op_out, last_op;
	sfp_op_e knd;
	int num_errors, n_compared, b;
	logic [7:0] ops[4] = '{8'h20, 8'h52, 8'hD8, 8'h02};
	sfp_op_e kinds[4] = '{SFP_OP_SE, SFP_OP_BE32, SFP_OP_BE64, SFP_OP_PP};

	sfp_flash_guard i_sfp_flash_guard (
		.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .cs_b_in(cs_b), .sclk_in(sclk),
		.si_in(si), .hold_b_in(hold_b), .wp_b_in(wp_b_in), .so_out(so), .so_oe_out(so_oe),
		.top_bottom_select_in(top_bottom_select_in), .quad_mode_in(quad_mode_in),
		.factory_lock_in(factory_lock_in), .busy_in(busy_in), .op_out(op_out),
		.protect_level_out(protect_level_out), .write_enable_latch_out(write_enable_latch_out),
		.otp_mode_out(otp_mode_out), .security_out(security_out), .hold_out(hold_out)
	);

	// The output has no pull-up, so a released line shows the inverse of its last bit.
	assign so_line = so_oe ? so : ~so;

	sfp_host_model i_sfp_host_model (
		.clk_in(clk_sys_in), .so_in(so_line), .cs_b_out(cs_b), .sclk_out(sclk), .si_out(si),
		.hold_b_out(hold_b)
	);

	initial
	begin
		clk_sys_in = 1'b0;
		forever #20 clk_sys_in = ~clk_sys_in;
	end

	// The request pulse lasts one cycle, so it is caught here and judged after the frame.
	always @(posedge clk_sys_in)
		if (op_out.valid === 1'b1)
		begin
			last_op <= op_out;
			op_seen <= 1'b1;
		end

	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : lfsr

	function automatic logic prot(input int l, input logic t, input int blk);
		int n;
		if (l == 0)
			return 1'b0;
		if (l > 5)
			return 1'b1;
		n = 1 << (l - 1);
		return t ? (blk < n) : (blk >= 32 - n);
	endfunction : prot

	task automatic report_and_stop();
		if (num_errors == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : report_and_stop

	task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			num_errors++;
			$display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask : chk_val

	task automatic chk_op(input logic v, input logic [20:0] a);
		logic [31:0] g;
		g = 32'h0;
		if (op_seen === 1'b1)
			g = {8'h01, last_op.kind, (knd == SFP_OP_CE) ? 21'h0 : last_op.addr};
		chk_val(g, v ? {8'h01, knd, (knd == SFP_OP_CE) ? 21'h0 : a} : 32'h0);
	endtask : chk_op

	task automatic frame(input logic [39:0] d, input int n);
		op_seen = 1'b0;
		i_sfp_host_model.begin_frame();
		for (int i = 0; i < n; i++)
			i_sfp_host_model.shift(d[39 - 8 * i -: 8], 8, rx);
		i_sfp_host_model.end_frame();
	endtask : frame

	task automatic write_enable_cmd();
		frame({8'h06, 32'h0}, 1);
		write_enable_latch = 1'b1;
	endtask : write_enable_cmd

	task automatic wrsr(input logic [7:0] s);
		write_enable_cmd();
		frame({8'h01, s, 24'h0}, 2);
		// A refused status write leaves the latch set.
		if (!(lk && !wp_b_in && !quad_mode_in))
		begin
			lvl = s[5:2];
			lk = s[7];
			write_enable_latch = 1'b0;
		end
	endtask : wrsr

	task automatic wr(input logic [7:0] op, input sfp_op_e k, input logic [20:0] a,
			input int n, input logic ok);
		knd = k;
		write_enable_cmd();
		frame({op, 3'b000, a, 8'h5A}, n);
		chk_op(ok, a);
		write_enable_latch = !ok;
	endtask : wr

	task automatic rdsr();
		i_sfp_host_model.begin_frame();
		i_sfp_host_model.shift(8'h05, 8, rx);
		i_sfp_host_model.shift(8'h00, 8, rx);
		chk_val(so_oe, 1'b1);
		chk_val(rx, {lk, 1'b0, lvl, write_enable_latch, 1'b0});
		i_sfp_host_model.shift(8'h00, 3, rx);
		i_sfp_host_model.end_frame();
	endtask : rdsr

	initial
	begin
		rst_b_in = 1'b0;
		wp_b_in = 1'b1;
		top_bottom_select_in = 1'b0;
		quad_mode_in = 1'b0;
		factory_lock_in = 1'b0;
		busy_in = 1'b0;
		num_errors = 0;
		n_compared = 0;
		lvl = 4'h0;
		lk = 1'b0;
		write_enable_latch = 1'b0;
		rnd = 8'h28;
		op_seen = 1'b0;
		repeat (4) @(posedge clk_sys_in);
		#1;
		rst_b_in = 1'b1;
		repeat (4) @(posedge clk_sys_in);
		#1;
		chk_val({protect_level_out, write_enable_latch_out, otp_mode_out, security_out,
			hold_out, so_oe}, 32'h0);
		for (int t = 0; t < 2; t++)
			for (int l = 0; l < 16; l++)
			begin
				top_bottom_select_in = t[0];
				wrsr({2'b00, l[3:0], 2'b00});
				chk_val(protect_level_out, lvl);
				if (l == 5)
					rdsr();
				rnd = lfsr(rnd);
				b = (l == 0 || l[0] || l > 5) ? int'(rnd[4:0]) :
					(t == 1 ? 1 << (l - 1) : 31 - (1 << (l - 1)));
				adr = {b[4:0], rnd, 8'h00};
				wr(ops[l % 4], kinds[l % 4], adr, (l % 4 == 3) ? 5 : 4,
					!prot(l, t[0], b));
			end
		wr(8'h60, SFP_OP_CE, 21'h0, 1, 1'b0);
		wrsr(8'h00);
		wr(8'hC7, SFP_OP_CE, 21'h0, 1, 1'b1);
		i_sfp_host_model.begin_frame();
		i_sfp_host_model.shift(8'hFF, 8, rx);
		i_sfp_host_model.shift(8'h06, 8, rx);
		chk_val(so_oe, 1'b0);
		i_sfp_host_model.end_frame();
		chk_val(write_enable_latch_out, 1'b0);
		i_sfp_host_model.begin_frame();
		i_sfp_host_model.shift(8'h06, 7, rx);
		i_sfp_host_model.end_frame();
		chk_val(write_enable_latch_out, 1'b0);
		wr(8'h20, SFP_OP_SE, 21'h0A000, 5, 1'b0);
		busy_in = 1'b1;
		wr(8'h20, SFP_OP_SE, 21'h0A000, 4, 1'b0);
		busy_in = 1'b0;
		wrsr(8'h84);
		i_sfp_host_model.set_mode3(1'b1);
		rdsr();
		wp_b_in = 1'b0;
		wrsr(8'h00);
		chk_val(protect_level_out, lvl);
		quad_mode_in = 1'b1;
		wrsr(8'h00);
		chk_val(protect_level_out, lvl);
		quad_mode_in = 1'b0;
		wp_b_in = 1'b1;
		i_sfp_host_model.set_mode3(1'b0);
		frame({8'hA1, 32'h0}, 1);
		chk_val(otp_mode_out, 1'b1);
		wr(8'h20, SFP_OP_SE, 21'h10000, 4, 1'b0);
		wr(8'h02, SFP_OP_PP, 21'h001FF, 5, 1'b1);
		chk_val(last_op.otp, 1'b1);
		write_enable_cmd();
		frame({8'hA3, 32'h0}, 1);
		chk_val(security_out, 2'b10);
		wr(8'h02, SFP_OP_PP, 21'h001FF, 5, 1'b0);
		wr(8'h02, SFP_OP_PP, 21'h00200, 5, 1'b1);
		factory_lock_in = 1'b1;
		wr(8'h02, SFP_OP_PP, 21'h00200, 5, 1'b0);
		chk_val(security_out, 2'b11);
		frame({8'hA2, 32'h0}, 1);
		chk_val(otp_mode_out, 1'b0);
		frame({8'h04, 32'h0}, 1);
		chk_val(write_enable_latch_out, 1'b0);
		i_sfp_host_model.begin_frame();
		i_sfp_host_model.shift(8'h06, 4, rx);
		i_sfp_host_model.set_hold(1'b0);
		chk_val({hold_out, so_oe}, 2'b10);
		i_sfp_host_model.shift(8'hFF, 4, rx);
		i_sfp_host_model.set_hold(1'b1);
		chk_val(hold_out, 1'b0);
		i_sfp_host_model.shift(8'h60, 4, rx);
		i_sfp_host_model.end_frame();
		chk_val(write_enable_latch_out, 1'b1);
		quad_mode_in = 1'b1;
		i_sfp_host_model.begin_frame();
		i_sfp_host_model.set_hold(1'b0);
		chk_val(hold_out, 1'b0);
		quad_mode_in = 1'b0;
		i_sfp_host_model.set_hold(1'b0);
		chk_val(hold_out, 1'b1);
		i_sfp_host_model.end_frame();
		chk_val(hold_out, 1'b0);
		i_sfp_host_model.set_hold(1'b1);
		report_and_stop();
	end

	// The full sequence needs about 1 ms, so this leaves ample margin.
	initial
	begin
		#3000000;
		num_errors++;
		report_and_stop();
	end
endmodule : serial_flash_protect_otp_hold_tb
